/* logic/spc_pkg.sv */
// constants, opcodes and register map of the servo parameter command set
package spc_pkg;

  // apb register byte addresses
  localparam logic [11:0] ADDR_CMD = 12'h000;
  localparam logic [11:0] ADDR_DATA = 12'h004;
  localparam logic [11:0] ADDR_STATUS = 12'h008;
  localparam logic [11:0] ADDR_RESP = 12'h00C;
  localparam logic [11:0] ADDR_ALARM = 12'h010;

  // command word fields
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_GIVEN_BIT = 8;

  // status word fields
  localparam int ST_ERROR_BIT = 0;
  localparam int ST_SLOT_LSB = 1;
  localparam int ST_PROGRAM_BIT = 5;
  localparam int ST_DAISY_BIT = 6;
  localparam int ST_LPF_OFF_BIT = 7;

  // alarm word fields
  localparam int AL_EXCESS_BIT = 0;
  localparam int AL_THERMAL_BIT = 1;
  localparam int AL_PROG_BIT = 2;
  localparam int AL_OTHER_BIT = 3;
  localparam int AL_READY_BIT = 4;

  // command opcodes
  localparam logic [7:0] OP_CHANNEL_ACCEL = 8'h01;
  localparam logic [7:0] OP_ERASE_SLOT = 8'h02;
  localparam logic [7:0] OP_SELECT_SLOT = 8'h03;
  localparam logic [7:0] OP_ALARM_RESET = 8'h04;
  localparam logic [7:0] OP_LINK_MODE = 8'h05;
  localparam logic [7:0] OP_EXCESS_LIMIT = 8'h06;
  localparam logic [7:0] OP_PULSE_RES = 8'h07;
  localparam logic [7:0] OP_CHANNEL_VEL = 8'h08;
  localparam logic [7:0] OP_DEAD_BAND = 8'h09;
  localparam logic [7:0] OP_SENSE_FLIP = 8'h0A;
  localparam logic [7:0] OP_FRICTION = 8'h0B;
  localparam logic [7:0] OP_PHASE_ORDER = 8'h0C;
  localparam logic [7:0] OP_FF_GAIN = 8'h0D;
  localparam logic [7:0] OP_BYPASS_SPEED = 8'h0E;
  localparam logic [7:0] OP_LOWPASS_FREQ = 8'h0F;
  localparam logic [7:0] OP_FB_RES = 8'h10;
  localparam logic [7:0] OP_GLOBAL_ACCEL = 8'h11;
  localparam logic [7:0] OP_GLOBAL_VEL = 8'h12;
  localparam logic [7:0] OP_QUERY = 8'h20;
  localparam logic [7:0] OP_END_PROGRAM = 8'h21;

  // value limits (accel/velocity in 0.01 units, gain in 0.0001 units)
  localparam logic [31:0] MAX_SLOT = 32'h0000000F;
  localparam logic [31:0] MAX_LIMIT = 32'h05F5E0FF;
  localparam logic [31:0] MAX_PULSE_RES = 32'h00000005;
  localparam logic [31:0] MAX_DEAD_BAND = 32'h00000FFF;
  localparam logic [31:0] MAX_FRICTION = 32'h000007FF;
  localparam logic [31:0] MAX_GAIN = 32'h00002710;
  localparam logic [31:0] MIN_LOWPASS = 32'h0000000A;
  localparam logic [31:0] MAX_LOWPASS = 32'h000001F4;
  localparam logic [31:0] MAX_BIT = 32'h00000001;
  localparam logic [15:0] DEF_MAX_ACCEL = 16'h0FA0;
  localparam logic [15:0] DEF_MAX_VEL = 16'h012C;

  // reset values
  localparam logic [26:0] RST_LIMIT = 27'h000C350;
  localparam logic [2:0] RST_PULSE_RES = 3'h0;
  localparam logic RST_LINK_MODE = 1'b0;

  typedef enum logic {st_standby, st_program} spc_state_type;

endpackage : spc_pkg

/* logic/spc_servo_params.sv */
// servo parameter command interpreter with apb register access
// Operation
// R01: channel_accel only while slot programming, else error
// R02: zero slot acceleration falls back to global_accel
// R03: channel_velocity only while slot programming, else error
// R04: zero slot velocity falls back to global_velocity
// R05: erase_slot_program clears slot 0-15, default 0
// R06: select_program_slot picks slot 0-15, default 0
// R07: host programs slots only with servo off
// R08: alarm reset clears only three alarm kinds
// R09: link_topology_mode takes effect only at power-on
// R10: error above limit raises alarm, opens ready
// R11: zero excess_error_limit disables excess detection
// R12: pulse_train_resolution picks six codes, immediate effect
// R13: position_dead_band holds 0 to 4095
// R14: scale_sense_flip reverses position counting direction
// R15: static_friction_offset 0-2047, zero disables compensation
// R16: feedback_phase_order sets which phase leads
// R17: feedforward_gain 0 to 1.0000, zero cancels
// R18: filter_bypass_speed toggles filters, zero keeps active
// R19: primary_lowpass_freq 10-500 Hz, zero means off
// R20: feedback_resolution 1 suppresses A/B unless fixed 12-bit
// R21: every stored parameter readable by query
// R22: out-of-range value rejected, old value kept
`timescale 1ns/1ps
module spc_servo_params
  import spc_pkg::*;
#(
  parameter logic [15:0] MAX_ACCEL = DEF_MAX_ACCEL,
  parameter logic [15:0] MAX_VEL = DEF_MAX_VEL
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // servo loop status, same clock
  input wire logic [31:0] pos_err_mag,
  input wire logic [15:0] motor_speed,
  input wire logic thermal_trip,
  input wire logic prog_fault,
  input wire logic other_alarm,
  input wire logic resolver_12bit_fixed,
  // slot execution pins
  input wire logic run_req,
  input wire logic [3:0] run_slot,
  // settings to servo loop
  output logic [15:0] run_accel,
  output logic [15:0] run_vel,
  output logic driver_ready_output,
  output logic link_daisy,
  output logic [2:0] pulse_res_code,
  output logic [11:0] dead_band,
  output logic sense_flip,
  output logic [10:0] friction_offset,
  output logic phase_b_leads,
  output logic phase_ab_enable,
  output logic [13:0] ff_gain,
  output logic ff_enable,
  output logic filter_active,
  output logic [8:0] lowpass_freq,
  output logic lowpass_off
);

  ////////////////////////////////////////////////////////////////////////////
  // stored parameters
  spc_state_type state;
  logic [3:0] sel_slot;
  logic cmd_error;
  logic [15:0] slot_accel [16];
  logic [15:0] slot_vel [16];
  logic [15:0] global_accel;
  logic [15:0] global_vel;
  logic link_mode;
  logic [26:0] excess_limit;
  logic [2:0] pulse_res;
  logic [11:0] dband;
  logic flip;
  logic [10:0] fric;
  logic phase_order;
  logic [13:0] ffg;
  logic [15:0] bypass_speed;
  logic [8:0] lpf;
  logic fb_res;
  logic alarm_excess;
  logic alarm_thermal;
  logic alarm_prog;
  logic [31:0] data_reg;
  logic [31:0] resp;
  logic link_taken;

  ////////////////////////////////////////////////////////////////////////////
  // apb slave
  logic setup;
  logic mapped;
  logic wr_acc;
  logic cmd_go;
  logic [7:0] op;
  logic [31:0] arg;
  logic [31:0] read_mux;

  assign setup = psel && !penable;
  assign mapped = (paddr == ADDR_CMD) || (paddr == ADDR_DATA) || (paddr == ADDR_STATUS) ||
    (paddr == ADDR_RESP) || (paddr == ADDR_ALARM);
  assign wr_acc = psel && penable && pwrite && pready && !pslverr;
  assign cmd_go = wr_acc && (paddr == ADDR_CMD);
  assign op = pwdata[CMD_OP_LSB +: 8];
  assign arg = pwdata[CMD_GIVEN_BIT] ? data_reg : 32'h00000000;

  always_comb begin
    read_mux = 32'h00000000;
    case (paddr)
      ADDR_DATA: read_mux = data_reg;
      ADDR_RESP: read_mux = resp;
      ADDR_STATUS: begin
        read_mux[ST_ERROR_BIT] = cmd_error;
        read_mux[ST_SLOT_LSB +: 4] = sel_slot;
        read_mux[ST_PROGRAM_BIT] = (state == st_program);
        read_mux[ST_DAISY_BIT] = link_daisy;
        read_mux[ST_LPF_OFF_BIT] = lowpass_off;
      end
      ADDR_ALARM: begin
        read_mux[AL_EXCESS_BIT] = alarm_excess;
        read_mux[AL_THERMAL_BIT] = alarm_thermal;
        read_mux[AL_PROG_BIT] = alarm_prog;
        read_mux[AL_OTHER_BIT] = other_alarm;
        read_mux[AL_READY_BIT] = driver_ready_output;
      end
      default: read_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= setup;
      pslverr <= setup && !mapped;
      if (setup && !pwrite) begin
        prdata <= read_mux;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      data_reg <= 32'h00000000;
    end else if (wr_acc && (paddr == ADDR_DATA)) begin
      data_reg <= pwdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // query readback
  function automatic logic [31:0] param_value(input logic [7:0] sel);
    param_value = 32'h00000000;
    case (sel)
      OP_SELECT_SLOT: param_value = {28'h0000000, sel_slot};
      OP_CHANNEL_ACCEL: param_value = {16'h0000, slot_accel[sel_slot]};
      OP_CHANNEL_VEL: param_value = {16'h0000, slot_vel[sel_slot]};
      OP_GLOBAL_ACCEL: param_value = {16'h0000, global_accel};
      OP_GLOBAL_VEL: param_value = {16'h0000, global_vel};
      OP_LINK_MODE: param_value = {31'h00000000, link_mode};
      OP_EXCESS_LIMIT: param_value = {5'h00, excess_limit};
      OP_PULSE_RES: param_value = {29'h00000000, pulse_res};
      OP_DEAD_BAND: param_value = {20'h00000, dband};
      OP_SENSE_FLIP: param_value = {31'h00000000, flip};
      OP_FRICTION: param_value = {21'h000000, fric};
      OP_PHASE_ORDER: param_value = {31'h00000000, phase_order};
      OP_FF_GAIN: param_value = {18'h00000, ffg};
      OP_BYPASS_SPEED: param_value = {16'h0000, bypass_speed};
      OP_LOWPASS_FREQ: param_value = {23'h000000, lpf};
      OP_FB_RES: param_value = {31'h00000000, fb_res};
      default: param_value = 32'h00000000;
    endcase
  endfunction : param_value

  ////////////////////////////////////////////////////////////////////////////
  // command interpreter
  logic bad;

  always_comb begin
    bad = 1'b0;
    case (op)
      OP_CHANNEL_ACCEL: bad = (state != st_program) || (arg > {16'h0000, MAX_ACCEL}); // [R01]
      OP_CHANNEL_VEL: bad = (state != st_program) || (arg > {16'h0000, MAX_VEL}); // [R03]
      OP_ERASE_SLOT, OP_SELECT_SLOT: bad = arg > MAX_SLOT;
      OP_GLOBAL_ACCEL: bad = arg > {16'h0000, MAX_ACCEL};
      OP_GLOBAL_VEL, OP_BYPASS_SPEED: bad = arg > {16'h0000, MAX_VEL};
      OP_LINK_MODE, OP_SENSE_FLIP, OP_PHASE_ORDER, OP_FB_RES: bad = arg > MAX_BIT;
      OP_EXCESS_LIMIT: bad = arg > MAX_LIMIT;
      OP_PULSE_RES: bad = arg > MAX_PULSE_RES;
      OP_DEAD_BAND: bad = arg > MAX_DEAD_BAND;
      OP_FRICTION: bad = arg > MAX_FRICTION;
      OP_FF_GAIN: bad = arg > MAX_GAIN;
      OP_LOWPASS_FREQ: bad = (arg != 32'h00000000) &&
        ((arg < MIN_LOWPASS) || (arg > MAX_LOWPASS));
      OP_ALARM_RESET, OP_QUERY, OP_END_PROGRAM: bad = 1'b0;
      default: bad = 1'b1;
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cmd_error <= 1'b0;
      state <= st_standby;
      sel_slot <= 4'h0;
      resp <= 32'h00000000;
    end else if (cmd_go) begin
      cmd_error <= bad; // [R22]
      if (!bad) begin
        case (op)
          OP_SELECT_SLOT: begin
            sel_slot <= arg[3:0]; // [R06]
            state <= st_program;
          end
          OP_END_PROGRAM: state <= st_standby;
          OP_QUERY: resp <= param_value(data_reg[7:0]); // [R21]
          default: state <= state;
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 16; i++) begin
        slot_accel[i] <= 16'h0000;
        slot_vel[i] <= 16'h0000;
      end
    end else if (cmd_go && !bad) begin
      if (op == OP_CHANNEL_ACCEL) begin
        slot_accel[sel_slot] <= arg[15:0];
      end
      if (op == OP_CHANNEL_VEL) begin
        slot_vel[sel_slot] <= arg[15:0];
      end
      if (op == OP_ERASE_SLOT) begin
        slot_accel[arg[3:0]] <= 16'h0000; // [R05]
        slot_vel[arg[3:0]] <= 16'h0000;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      global_accel <= 16'h0000;
      global_vel <= 16'h0000;
      link_mode <= RST_LINK_MODE;
      excess_limit <= RST_LIMIT;
      pulse_res <= RST_PULSE_RES;
      dband <= 12'h000;
      flip <= 1'b0;
      fric <= 11'h000;
      phase_order <= 1'b0;
      ffg <= 14'h0000;
      bypass_speed <= 16'h0000;
      lpf <= 9'h000;
      fb_res <= 1'b0;
    end else if (cmd_go && !bad) begin // [R22]
      case (op)
        OP_GLOBAL_ACCEL: global_accel <= arg[15:0];
        OP_GLOBAL_VEL: global_vel <= arg[15:0];
        OP_LINK_MODE: link_mode <= arg[0];
        OP_EXCESS_LIMIT: excess_limit <= arg[26:0];
        OP_PULSE_RES: pulse_res <= arg[2:0]; // [R12]
        OP_DEAD_BAND: dband <= arg[11:0]; // [R13]
        OP_SENSE_FLIP: flip <= arg[0];
        OP_FRICTION: fric <= arg[10:0]; // [R15]
        OP_PHASE_ORDER: phase_order <= arg[0];
        OP_FF_GAIN: ffg <= arg[13:0]; // [R17]
        OP_BYPASS_SPEED: bypass_speed <= arg[15:0];
        OP_LOWPASS_FREQ: lpf <= arg[8:0]; // [R19]
        OP_FB_RES: fb_res <= arg[0];
        default: lpf <= lpf;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // power-on capture of link mode
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      link_taken <= 1'b0;
      link_daisy <= 1'b0;
    end else if (!link_taken) begin
      link_taken <= 1'b1;
      link_daisy <= link_mode; // [R09]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // alarms and ready
  logic clear_req;
  logic excess_hit;

  assign clear_req = cmd_go && (op == OP_ALARM_RESET);
  assign excess_hit = (excess_limit != 27'h0000000) && (pos_err_mag > {5'h00, excess_limit}); // [R10] [R11]

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      alarm_excess <= 1'b0;
      alarm_thermal <= 1'b0;
      alarm_prog <= 1'b0;
      driver_ready_output <= 1'b0;
    end else begin
      alarm_excess <= excess_hit || (alarm_excess && !clear_req); // [R08]
      alarm_thermal <= thermal_trip || (alarm_thermal && !clear_req);
      alarm_prog <= prog_fault || (alarm_prog && !clear_req);
      driver_ready_output <= !(alarm_excess || alarm_thermal || alarm_prog || other_alarm); // [R10]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // slot execution
  logic [1:0] run_sync;
  logic [3:0] slot_s1;
  logic [3:0] slot_s2;
  logic run_prev;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      run_sync <= 2'b00;
      slot_s1 <= 4'h0;
      slot_s2 <= 4'h0;
      run_prev <= 1'b0;
    end else begin
      run_sync <= {run_sync[0], run_req};
      slot_s1 <= run_slot;
      slot_s2 <= slot_s1;
      run_prev <= run_sync[1];
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      run_accel <= 16'h0000;
      run_vel <= 16'h0000;
    end else if (run_sync[1] && !run_prev) begin
      run_accel <= (slot_accel[slot_s2] == 16'h0000) ? global_accel : slot_accel[slot_s2]; // [R02]
      run_vel <= (slot_vel[slot_s2] == 16'h0000) ? global_vel : slot_vel[slot_s2]; // [R04]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // settings to servo loop
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pulse_res_code <= RST_PULSE_RES;
      dead_band <= 12'h000;
      sense_flip <= 1'b0;
      friction_offset <= 11'h000;
      phase_b_leads <= 1'b0;
      phase_ab_enable <= 1'b1;
      ff_gain <= 14'h0000;
      ff_enable <= 1'b0;
      filter_active <= 1'b1;
      lowpass_freq <= 9'h000;
      lowpass_off <= 1'b1;
    end else begin
      pulse_res_code <= pulse_res; // [R12]
      dead_band <= dband; // [R13]
      sense_flip <= flip; // [R14]
      friction_offset <= fric; // [R15]
      phase_b_leads <= phase_order; // [R16]
      phase_ab_enable <= !fb_res || resolver_12bit_fixed; // [R20]
      ff_gain <= ffg;
      ff_enable <= ffg != 14'h0000; // [R17]
      filter_active <= (bypass_speed == 16'h0000) || (motor_speed < bypass_speed); // [R18]
      lowpass_freq <= lpf;
      lowpass_off <= lpf == 9'h000; // [R19]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  a_accel_standby: assert property (@(posedge clk_sys) disable iff (rst) // [R01]
    cmd_go && op == OP_CHANNEL_ACCEL && state == st_standby |=> cmd_error)
    else $error("channel accel accepted in standby");
  a_vel_standby: assert property (@(posedge clk_sys) disable iff (rst) // [R03]
    cmd_go && op == OP_CHANNEL_VEL && state == st_standby
      |=> cmd_error && $stable(slot_vel[sel_slot]))
    else $error("channel velocity accepted in standby");
  a_accel_fallback: assert property (@(posedge clk_sys) disable iff (rst) // [R02]
    run_sync[1] && !run_prev && slot_accel[slot_s2] == 16'h0000 |=> run_accel == $past(global_accel))
    else $error("zero slot accel did not use global");
  a_excess_raise: assert property (@(posedge clk_sys) disable iff (rst) // [R10]
    excess_hit |=> alarm_excess ##1 !driver_ready_output)
    else $error("excess error did not open ready");
  a_limit_off: assert property (@(posedge clk_sys) disable iff (rst) // [R11]
    $rose(alarm_excess) |-> $past(excess_limit) != 27'h0000000)
    else $error("excess alarm raised with zero limit");
  a_clear_keep: assert property (@(posedge clk_sys) disable iff (rst) // [R08]
    clear_req && other_alarm |=> ##1 !driver_ready_output)
    else $error("alarm reset cleared other alarm");
  a_link_fixed: assert property (@(posedge clk_sys) disable iff (rst) // [R09]
    link_taken |=> $stable(link_daisy))
    else $error("link mode changed after power-on");
  a_range_keep: assert property (@(posedge clk_sys) disable iff (rst) // [R22]
    cmd_go && op == OP_DEAD_BAND && arg > MAX_DEAD_BAND |=> cmd_error && $stable(dband))
    else $error("out of range dead band stored");
  a_phase_off: assert property (@(posedge clk_sys) disable iff (rst) // [R20]
    fb_res && !resolver_12bit_fixed |=> !phase_ab_enable)
    else $error("phase A/B output not suppressed");
  a_filter_on: assert property (@(posedge clk_sys) disable iff (rst) // [R18]
    bypass_speed == 16'h0000 |=> filter_active)
    else $error("filters inactive with zero bypass speed");
  a_slot_select: assert property (@(posedge clk_sys) disable iff (rst) // [R06]
    cmd_go && op == OP_SELECT_SLOT && !pwdata[CMD_GIVEN_BIT]
      |=> sel_slot == 4'h0 && state == st_program)
    else $error("default slot not zero");

endmodule : spc_servo_params

/* verif/spc_host_model.sv */
// host terminal model: apb master that issues register transfers
`timescale 1ns/1ps
module spc_host_model (
  // clock
  input wire logic clk_sys,
  // apb master side
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  // bus idle from time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
  end
  ////////////////////////////////////////////////////////////////////////////
  // one transfer; slot programs go out with no servo enable driven
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
endmodule : spc_host_model

/* verif/servo_parameter_command_set_bench.sv */
// self-checking bench for the servo parameter command set
`timescale 1ns/1ps
module servo_parameter_command_set_bench
  import spc_pkg::*;
();
  logic clk_sys, rst, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, pos_err_mag, rd;
  logic [15:0] motor_speed, run_accel, run_vel;
  logic thermal_trip, prog_fault, other_alarm, resolver_12bit_fixed, run_req, er;
  logic [3:0] run_slot;
  logic driver_ready_output, link_daisy, sense_flip, phase_b_leads, phase_ab_enable;
  logic ff_enable, filter_active, lowpass_off;
  logic [2:0] pulse_res_code;
  logic [11:0] dead_band;
  logic [10:0] friction_offset;
  logic [13:0] ff_gain;
  logic [8:0] lowpass_freq;
  int num_errors = 0;
  int num_checks = 0;
  logic [7:0] t_op [8] = '{OP_DEAD_BAND, OP_FRICTION, OP_FF_GAIN, OP_LOWPASS_FREQ,
                           OP_PULSE_RES, OP_SENSE_FLIP, OP_PHASE_ORDER, OP_EXCESS_LIMIT};
  logic [31:0] t_max [8] = '{MAX_DEAD_BAND, MAX_FRICTION, MAX_GAIN, MAX_LOWPASS,
                             MAX_PULSE_RES, MAX_BIT, MAX_BIT, MAX_LIMIT};
  ////////////////////////////////////////////////////////////////////////////
  spc_servo_params dut_u (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pos_err_mag(pos_err_mag), .motor_speed(motor_speed),
    .thermal_trip(thermal_trip), .prog_fault(prog_fault), .other_alarm(other_alarm),
    .resolver_12bit_fixed(resolver_12bit_fixed), .run_req(run_req), .run_slot(run_slot),
    .run_accel(run_accel), .run_vel(run_vel), .driver_ready_output(driver_ready_output),
    .link_daisy(link_daisy), .pulse_res_code(pulse_res_code), .dead_band(dead_band),
    .sense_flip(sense_flip), .friction_offset(friction_offset),
    .phase_b_leads(phase_b_leads), .phase_ab_enable(phase_ab_enable), .ff_gain(ff_gain),
    .ff_enable(ff_enable), .filter_active(filter_active), .lowpass_freq(lowpass_freq),
    .lowpass_off(lowpass_off));
  spc_host_model host_u (.clk_sys(clk_sys), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  task automatic test_done();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : test_done
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic rdreg(input logic [11:0] a);
    host_u.xfer(1'b0, a, 32'h00000000, rd, er);
  endtask : rdreg
  task automatic cmd(input logic [7:0] op, input logic g, input logic [31:0] arg);
    host_u.xfer(1'b1, ADDR_DATA, arg, rd, er);
    host_u.xfer(1'b1, ADDR_CMD, {23'h000000, g, op}, rd, er);
    repeat (2) @(posedge clk_sys);
  endtask : cmd
  task automatic err_is(input logic e);
    rdreg(ADDR_STATUS);
    chk({31'h00000000, rd[ST_ERROR_BIT]}, {31'h00000000, e});
  endtask : err_is
  task automatic run(input logic [3:0] s);
    run_slot <= s;
    @(posedge clk_sys);
    run_req <= 1'b1;
    repeat (6) @(posedge clk_sys);
    run_req <= 1'b0;
    repeat (4) @(posedge clk_sys);
  endtask : run
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (30000) @(posedge clk_sys);
    num_errors++;
    test_done();
  end
  initial begin
    rst = 1'b1;
    pos_err_mag = 32'h00000000;
    motor_speed = 16'h0000;
    {thermal_trip, prog_fault, other_alarm, resolver_12bit_fixed, run_req} = 5'h00;
    run_slot = 4'h0;
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (3) @(posedge clk_sys);
    chk(32'(driver_ready_output), 32'h1);
    chk(32'(pulse_res_code), 32'(RST_PULSE_RES));
    rdreg(ADDR_ALARM);
    chk(32'(rd[4:0]), 32'h10);
    rdreg(12'h100);
    chk(32'(er), 32'h1);
    // slot commands refused in standby
    cmd(OP_CHANNEL_ACCEL, 1'b1, 32'd1000);
    err_is(1'b1);
    cmd(OP_CHANNEL_VEL, 1'b1, 32'd100);
    err_is(1'b1);
    cmd(OP_GLOBAL_ACCEL, 1'b1, 32'd2000);
    cmd(OP_GLOBAL_VEL, 1'b1, 32'd150);
    cmd(OP_SELECT_SLOT, 1'b1, 32'd3);
    rdreg(ADDR_STATUS);
    chk(32'(rd[5:1]), 32'h13);
    cmd(OP_CHANNEL_ACCEL, 1'b1, 32'd1000);
    err_is(1'b0);
    cmd(OP_CHANNEL_VEL, 1'b1, 32'd0);
    err_is(1'b0);
    cmd(OP_SELECT_SLOT, 1'b0, 32'd9);
    rdreg(ADDR_STATUS);
    chk(32'(rd[4:1]), 32'h0);
    cmd(OP_CHANNEL_VEL, 1'b1, 32'd200);
    cmd(OP_END_PROGRAM, 1'b0, 32'd0);
    run(4'h3);
    chk(32'(run_accel), 32'd1000);
    chk(32'(run_vel), 32'd150);
    run(4'h0);
    chk(32'(run_vel), 32'd200);
    cmd(OP_ERASE_SLOT, 1'b1, 32'd3);
    cmd(OP_ERASE_SLOT, 1'b0, 32'd7);
    run(4'h3);
    chk(32'(run_accel), 32'd2000);
    run(4'h0);
    chk(32'(run_vel), 32'd150);
    // range limits: top value taken, one above refused
    for (int i = 0; i < 8; i++) begin
      cmd(t_op[i], 1'b1, t_max[i]);
      err_is(1'b0);
      cmd(t_op[i], 1'b1, t_max[i] + 32'h1);
      err_is(1'b1);
    end
    chk(32'(dead_band), 32'hFFF);
    chk(32'(friction_offset), 32'h7FF);
    chk({17'h0, ff_enable, ff_gain}, 32'h6710);
    chk({22'h0, lowpass_off, lowpass_freq}, 32'h1F4);
    chk({30'h0, sense_flip, phase_b_leads}, 32'h3);
    cmd(OP_QUERY, 1'b1, 32'(OP_DEAD_BAND));
    rdreg(ADDR_RESP);
    chk(rd, 32'hFFF);
    for (int c = 0; c < 6; c++) begin
      cmd(OP_PULSE_RES, 1'b1, 32'(c));
      chk(32'(pulse_res_code), 32'(c));
    end
    cmd(OP_FF_GAIN, 1'b1, 32'd0);
    chk(32'(ff_enable), 32'h0);
    cmd(OP_FRICTION, 1'b1, 32'd0);
    chk(32'(friction_offset), 32'h0);
    cmd(OP_LOWPASS_FREQ, 1'b1, MIN_LOWPASS - 32'h1);
    err_is(1'b1);
    cmd(OP_LOWPASS_FREQ, 1'b1, 32'd0);
    rdreg(ADDR_STATUS);
    chk({30'h0, lowpass_off, rd[ST_LPF_OFF_BIT]}, 32'h3);
    cmd(OP_FB_RES, 1'b1, 32'd1);
    chk(32'(phase_ab_enable), 32'h0);
    resolver_12bit_fixed <= 1'b1;
    repeat (3) @(posedge clk_sys);
    chk(32'(phase_ab_enable), 32'h1);
    motor_speed <= 16'd50;
    cmd(OP_BYPASS_SPEED, 1'b1, 32'd100);
    chk(32'(filter_active), 32'h1);
    motor_speed <= 16'd200;
    repeat (3) @(posedge clk_sys);
    chk(32'(filter_active), 32'h0);
    cmd(OP_BYPASS_SPEED, 1'b1, 32'd0);
    chk(32'(filter_active), 32'h1);
    cmd(OP_LINK_MODE, 1'b1, 32'd1);
    chk(32'(link_daisy), 32'h0);
    // excess error at and above the limit, then selective clear
    cmd(OP_EXCESS_LIMIT, 1'b1, 32'd100);
    pos_err_mag <= 32'd100;
    repeat (3) @(posedge clk_sys);
    rdreg(ADDR_ALARM);
    chk(32'(rd[AL_EXCESS_BIT]), 32'h0);
    pos_err_mag <= 32'd101;
    {thermal_trip, prog_fault, other_alarm} <= 3'h7;
    repeat (3) @(posedge clk_sys);
    {thermal_trip, prog_fault} <= 2'h0;
    pos_err_mag <= 32'd0;
    rdreg(ADDR_ALARM);
    chk({27'h0, driver_ready_output, rd[3:0]}, 32'h0F);
    cmd(OP_ALARM_RESET, 1'b0, 32'd0);
    rdreg(ADDR_ALARM);
    chk(32'(rd[3:0]), 32'h8);
    other_alarm <= 1'b0;
    cmd(OP_EXCESS_LIMIT, 1'b1, 32'd0);
    pos_err_mag <= 32'h0FFFFFFF;
    repeat (3) @(posedge clk_sys);
    rdreg(ADDR_ALARM);
    chk(32'(rd[AL_EXCESS_BIT]), 32'h0);
    test_done();
  end
endmodule : servo_parameter_command_set_bench
